// *** rtl/tpci_cmd_interp.sv ***
`timescale 1ns/10ps
`include "tpci_params.svh"

// How it works
// - ghost clear command zeroes ghost row status
// - page cycle reply: nine bytes, fixed order
// - counts report cycle, memory and ghost pages
// - service events set sticky status bits
// - priority command stores enable and border bytes
// - border limits priorities while manager is enabled
// - priority reply: high, low, border, page
// - page request: eight bytes in, three out
// - start page used only without priority manager
// - request magazine byte decodes hex, back, forced
// - page info reply: seven bytes from table
// - ring index, subcode only for F1 subcodes

module tpci_cmd_interp
  import tpci_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    resetn_i,
  input  wire logic                    ce_i,
  input  wire logic                    wr_valid_i,
  input  wire logic [7:0]              wr_data_i,
  output      logic                    wr_ready_o,
  input  wire logic                    rd_ack_i,
  output      logic                    rd_valid_o,
  output      logic [7:0]              rd_data_o,
  input  wire logic [7:0]              ghost_row_seen_i,
  input  wire logic [5:0]              svc_event_i,
  input  wire logic                    table_reset_i,
  input  wire tpci_stats_t             stats_i,
  input  wire tpci_prio_t              prio_i,
  input  wire logic [7:0]              open_req_i,
  input  wire logic [7:0]              removed_mag_i,
  input  wire logic [7:0]              removed_page_i,
  input  wire logic                    acq_we_i,
  input  wire logic [`TPCI_MEM_AW-1:0] acq_addr_i,
  input  wire tpci_entry_t             acq_entry_i,
  output      logic                    acq_ready_o,
  output      logic                    req_valid_o,
  output      tpci_req_t               req_o,
  output      logic                    prio_enable_o,
  output      logic [7:0]              prio_border_o
);

  // ***************************************
  // helper functions
  // ***************************************

  // number of write parameters of a command
  function automatic logic [3:0] wr_len(input logic [7:0] code);
    case (code)
      `TPCI_CMD_PRIO_SET: wr_len = 4'h2;
      `TPCI_CMD_PAGE_REQ: wr_len = 4'h8;
      `TPCI_CMD_RD_INFO:  wr_len = 4'h2;
      `TPCI_CMD_CHG_INFO: wr_len = 4'h3;
      default:            wr_len = 4'h0;
    endcase
  endfunction

  // number of read parameters of a command
  function automatic logic [3:0] rd_len(input logic [7:0] code);
    case (code)
      `TPCI_CMD_RD_CYCLE: rd_len = 4'h9;
      `TPCI_CMD_RD_PRIO:  rd_len = 4'h5;
      `TPCI_CMD_PAGE_REQ: rd_len = 4'h3;
      `TPCI_CMD_RD_INFO:  rd_len = 4'h7;
      default:            rd_len = 4'h0;
    endcase
  endfunction

  // table address from magazine and page bytes
  function automatic logic [`TPCI_MEM_AW-1:0] tab_addr(
    input logic [7:0] mag,
    input logic [7:0] page
  );
    tab_addr = {mag[2:0], page};
  endfunction

  // ***************************************
  // state
  // ***************************************

  tpci_state_t state_reg;
  logic [7:0]  code_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  par_reg [0:`TPCI_PAR_MAX-1];
  logic [7:0]  rpl_reg [0:`TPCI_RPL_MAX-1];
  logic [7:0]  ghost_reg;
  logic [5:0]  svc_reg;
  logic        prio_en_reg;
  logic [7:0]  border_reg;
  logic [7:0]  rd_data_reg;
  logic        req_valid_reg;
  tpci_req_t   req_reg;
  tpci_entry_t mem_rdata;
  logic        take;
  logic        cmd_clr;
  logic        chg_we;
  logic [7:0]  prio_eff;

  assign take    = wr_valid_i && wr_ready_o;
  assign cmd_clr = (state_reg == TPCI_EXEC) &&
                   (code_reg == `TPCI_CMD_GHOST_CLR);
  assign chg_we  = (state_reg == TPCI_EXEC) &&
                   (code_reg == `TPCI_CMD_CHG_INFO);

  // handshake outputs
  assign wr_ready_o  = (state_reg == TPCI_IDLE) ||
                       (state_reg == TPCI_PARAM);
  assign rd_valid_o  = (state_reg == TPCI_READ);
  assign rd_data_o   = rd_data_reg;
  assign acq_ready_o = !chg_we;
  assign req_valid_o = req_valid_reg;
  assign req_o       = req_reg;
  assign prio_enable_o = prio_en_reg;
  assign prio_border_o = border_reg;

  // ***************************************
  // page table
  // ***************************************

  tpci_page_mem u_mem (
    .clk_sys_i  (clk_sys_i),
    .ce_i       (ce_i),
    .we_flags_i (chg_we || acq_we_i),
    .we_body_i  (acq_we_i && !chg_we),
    .waddr_i    (chg_we ? tab_addr(par_reg[0], par_reg[1]) : acq_addr_i),
    .wdata_i    (chg_we ? {par_reg[2], 56'h00_0000_0000_0000}
                        : acq_entry_i),
    .raddr_i    (tab_addr(par_reg[0], par_reg[1])),
    .rdata_o    (mem_rdata)
  );

  // ***************************************
  // command sequencer
  // ***************************************

  // code, then writes, then execute, then reads
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg <= TPCI_IDLE;
      code_reg  <= 8'h00;
      cnt_reg   <= 4'h0;
    end else if (ce_i) begin
      case (state_reg)
        TPCI_IDLE: begin
          if (take) begin
            code_reg  <= wr_data_i;
            cnt_reg   <= 4'h0;
            state_reg <= (wr_len(wr_data_i) == 4'h0) ? TPCI_EXEC
                                                      : TPCI_PARAM;
          end
        end
        TPCI_PARAM: begin
          if (take) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg + 4'h1 == wr_len(code_reg)) begin
              state_reg <= (code_reg == `TPCI_CMD_RD_INFO) ? TPCI_LOOK
                                                          : TPCI_EXEC;
            end
          end
        end
        TPCI_LOOK: state_reg <= TPCI_EXEC;         // table read latency
        TPCI_EXEC: begin
          cnt_reg   <= 4'h0;
          state_reg <= (rd_len(code_reg) == 4'h0) ? TPCI_IDLE
                                                   : TPCI_READ;
        end
        TPCI_READ: begin
          if (rd_ack_i) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg + 4'h1 == rd_len(code_reg)) begin
              state_reg <= TPCI_IDLE;
            end
          end
        end
        default: state_reg <= TPCI_IDLE;
      endcase
    end
  end

  // write parameter capture
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `TPCI_PAR_MAX; i++) begin
        par_reg[i] <= 8'h00;
      end
    end else if (ce_i && take && state_reg == TPCI_PARAM) begin
      par_reg[cnt_reg[2:0]] <= wr_data_i;
    end
  end

  // ***************************************
  // status bits
  // ***************************************

  // ghost rows 24..31 seen; set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ghost_reg <= 8'h00;
    end else if (ce_i) begin
      ghost_reg <= ((cmd_clr || table_reset_i) ? 8'h00 : ghost_reg)
                   | ghost_row_seen_i;
    end
  end

  // sticky data service bits
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      svc_reg <= 6'h00;
    end else if (ce_i) begin
      svc_reg <= (table_reset_i ? 6'h00 : svc_reg) | svc_event_i;
    end
  end

  // priority manager settings
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      prio_en_reg <= 1'(`TPCI_PRIO_EN_RST);
      border_reg  <= `TPCI_BORDER_RST;
    end else if (ce_i && state_reg == TPCI_EXEC &&
                 code_reg == `TPCI_CMD_PRIO_SET) begin
      prio_en_reg <= par_reg[0][`TPCI_PRIO_EN_BIT];
      border_reg  <= par_reg[1];
    end
  end

  // requested priority clamped to the border while the priority manager is enabled
  assign prio_eff = (prio_en_reg && par_reg[4] > border_reg) ?
                    border_reg : par_reg[4];

  // ***************************************
  // page request
  // ***************************************

  // one-cycle request pulse with decoded fields
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      req_valid_reg <= 1'b0;
      req_reg       <= '0;
    end else if (ce_i) begin
      req_valid_reg <= (state_reg == TPCI_PARAM) && take &&
                       (code_reg == `TPCI_CMD_PAGE_REQ) &&
                       (cnt_reg == 4'h7);
      if (state_reg == TPCI_PARAM && take && cnt_reg == 4'h7 &&
          code_reg == `TPCI_CMD_PAGE_REQ) begin
        req_reg.mag        <= par_reg[0][`TPCI_MAG_MSB:`TPCI_MAG_LSB];
        req_reg.hex        <= par_reg[0][`TPCI_REQ_HEX_BIT];
        req_reg.backward   <= par_reg[0][`TPCI_REQ_BACK_BIT];
        req_reg.forced     <= par_reg[0][`TPCI_REQ_FORCE_BIT];
        req_reg.page       <= par_reg[1];
        req_reg.subcode    <= {par_reg[2], par_reg[3]};
        req_reg.prio       <= prio_eff;
        req_reg.quantity   <= par_reg[5];
        req_reg.start_mag  <= par_reg[6];
        req_reg.start_page <= wr_data_i;
        req_reg.use_start  <= !prio_en_reg;
      end
    end
  end

  // ***************************************
  // replies
  // ***************************************

  // reply bytes latched at execute
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `TPCI_RPL_MAX; i++) begin
        rpl_reg[i] <= 8'h00;
      end
    end else if (ce_i && state_reg == TPCI_EXEC) begin
      case (code_reg)
        `TPCI_CMD_RD_CYCLE: begin
          rpl_reg[0] <= ghost_reg;
          rpl_reg[1] <= stats_i.cycle_cnt[15:8];
          rpl_reg[2] <= stats_i.cycle_cnt[7:0];
          rpl_reg[3] <= stats_i.mem_cnt[15:8];
          rpl_reg[4] <= stats_i.mem_cnt[7:0];
          rpl_reg[5] <= stats_i.ghost_cnt[15:8];
          rpl_reg[6] <= stats_i.ghost_cnt[7:0];
          rpl_reg[7] <= {2'b00, svc_reg};
          rpl_reg[8] <= {7'h00, stats_i.mem_full};
        end
        `TPCI_CMD_RD_PRIO: begin
          rpl_reg[0] <= prio_i.highest;
          rpl_reg[1] <= prio_i.lowest;
          rpl_reg[2] <= border_reg;
          rpl_reg[3] <= prio_i.low_mag;
          rpl_reg[4] <= prio_i.low_page;
        end
        `TPCI_CMD_PAGE_REQ: begin
          rpl_reg[0] <= open_req_i;
          rpl_reg[1] <= removed_mag_i;
          rpl_reg[2] <= removed_page_i;
        end
        `TPCI_CMD_RD_INFO: begin
          rpl_reg[0] <= mem_rdata.ptr[15:8];
          rpl_reg[1] <= mem_rdata.ptr[7:0];
          rpl_reg[2] <= mem_rdata.sub_cnt;
          rpl_reg[3] <= mem_rdata.ghost_cnt;
          if (mem_rdata.subcode[15:8] == `TPCI_RING_SUB_HI) begin
            rpl_reg[4] <= mem_rdata.ring_idx;
            rpl_reg[5] <= mem_rdata.subcode[15:8];
            rpl_reg[6] <= mem_rdata.subcode[7:0];
          end else begin
            rpl_reg[4] <= 8'h00;
            rpl_reg[5] <= 8'h00;
            rpl_reg[6] <= 8'h00;
          end
        end
        default: rpl_reg[0] <= rpl_reg[0];
      endcase
    end
  end

  // read data register follows the reply index; the first byte is
  // loaded at execute from its source, since rpl_reg is still old then
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rd_data_reg <= 8'h00;
    end else if (ce_i) begin
      if (state_reg == TPCI_EXEC) begin
        case (code_reg)
          `TPCI_CMD_RD_CYCLE: rd_data_reg <= ghost_reg;
          `TPCI_CMD_RD_PRIO:  rd_data_reg <= prio_i.highest;
          `TPCI_CMD_PAGE_REQ: rd_data_reg <= open_req_i;
          `TPCI_CMD_RD_INFO:  rd_data_reg <= mem_rdata.ptr[15:8];
          default:            rd_data_reg <= 8'h00;
        endcase
      end else if (state_reg == TPCI_READ && rd_ack_i &&
                   cnt_reg < 4'h8) begin
        rd_data_reg <= rpl_reg[cnt_reg + 4'h1];
      end
    end
  end

endmodule

// *** rtl/tpci_params.svh ***
`ifndef TPCI_PARAMS_SVH
`define TPCI_PARAMS_SVH

// command codes
`define TPCI_CMD_GHOST_CLR   8'h42
`define TPCI_CMD_RD_CYCLE    8'h29
`define TPCI_CMD_PRIO_SET    8'h38
`define TPCI_CMD_RD_PRIO     8'h37
`define TPCI_CMD_PAGE_REQ    8'h12
`define TPCI_CMD_RD_INFO     8'h20
`define TPCI_CMD_CHG_INFO    8'h22

// reset values of the priority settings
`define TPCI_PRIO_EN_RST     8'h00
`define TPCI_BORDER_RST      8'hFF

// page-request magazine byte fields, priority enable bit and memory-full bit
`define TPCI_MAG_LSB         0
`define TPCI_MAG_MSB         3
`define TPCI_REQ_HEX_BIT     5
`define TPCI_REQ_BACK_BIT    6
`define TPCI_REQ_FORCE_BIT   7
`define TPCI_PRIO_EN_BIT     0
`define TPCI_MEM_FULL_BIT    0

// subcode high byte that marks a ring-buffer request
`define TPCI_RING_SUB_HI     8'hF1

// page table geometry
`define TPCI_MEM_AW          11
`define TPCI_MEM_DEPTH       2048
`define TPCI_PAR_MAX         8
`define TPCI_RPL_MAX         9

`endif

// *** rtl/tpci_pkg.sv ***
package tpci_pkg;

  // one page table entry
  typedef struct packed {
    logic [7:0]  flags;
    logic [15:0] ptr;
    logic [7:0]  sub_cnt;
    logic [7:0]  ghost_cnt;
    logic [7:0]  ring_idx;
    logic [15:0] subcode;
  } tpci_entry_t;

  // page request handed to the acquisition side
  typedef struct packed {
    logic [3:0]  mag;
    logic        hex;
    logic        backward;
    logic        forced;
    logic [7:0]  page;
    logic [15:0] subcode;
    logic [7:0]  prio;
    logic [7:0]  quantity;
    logic [7:0]  start_mag;
    logic [7:0]  start_page;
    logic        use_start;
  } tpci_req_t;

  // statistics from acquisition
  typedef struct packed {
    logic [15:0] cycle_cnt;
    logic [15:0] mem_cnt;
    logic [15:0] ghost_cnt;
    logic        mem_full;
  } tpci_stats_t;

  // priority view of page memory
  typedef struct packed {
    logic [7:0] highest;
    logic [7:0] lowest;
    logic [7:0] low_mag;
    logic [7:0] low_page;
  } tpci_prio_t;

  typedef enum logic [2:0] {
    TPCI_IDLE, TPCI_PARAM, TPCI_LOOK, TPCI_EXEC, TPCI_READ
  } tpci_state_t;

endpackage

// *** rtl/tpci_page_mem.sv ***
`timescale 1ns/10ps
`include "tpci_params.svh"

module tpci_page_mem
  import tpci_pkg::*;
(
  input  wire logic                     clk_sys_i,
  input  wire logic                     ce_i,
  input  wire logic                     we_flags_i,
  input  wire logic                     we_body_i,
  input  wire logic [`TPCI_MEM_AW-1:0]  waddr_i,
  input  wire tpci_entry_t              wdata_i,
  input  wire logic [`TPCI_MEM_AW-1:0]  raddr_i,
  output      tpci_entry_t              rdata_o
);

  logic [7:0]  flag_mem [0:`TPCI_MEM_DEPTH-1];
  // flags sit in the top byte and keep a lane of their own
  logic [55:0] body_mem [0:`TPCI_MEM_DEPTH-1];
  tpci_entry_t rdata_reg;

  // flag lane and body lane are written separately
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && we_flags_i) begin
      flag_mem[waddr_i] <= wdata_i.flags;
    end
    if (ce_i && we_body_i) begin
      body_mem[waddr_i] <= wdata_i[55:0];
    end
  end

  // registered read, one cycle latency
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      rdata_reg <= {flag_mem[raddr_i], body_mem[raddr_i]};
    end
  end

  assign rdata_o = rdata_reg;

endmodule

// *** verification/tpci_cmd_interp_asserts.sv ***
`timescale 1ns/10ps
// **********
// checker
// **********
module tpci_cmd_interp_asserts
  import tpci_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  input wire logic       ce_i,
  input wire logic       wr_valid_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       wr_ready_o,
  input wire logic       rd_ack_i,
  input wire logic       rd_valid_o,
  input wire logic [7:0] rd_data_o,
  input wire logic       req_valid_o,
  input wire tpci_req_t  req_o,
  input wire logic       prio_enable_o,
  input wire logic [7:0] prio_border_o
);
  logic       tk;
  logic [3:0] pc;
  logic [7:0] cmd;
  logic [7:0] mb;
  logic [7:0] bv;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // byte taken by the interpreter
  assign tk = ce_i && wr_valid_i && wr_ready_o;

  // track command code and bytes still owed
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pc <= 4'h0;
    end else if (tk && pc == 4'h0) begin
      cmd <= wr_data_i;
      case (wr_data_i)
        8'h38, 8'h20: pc <= 4'h2;
        8'h22: pc <= 4'h3;
        8'h12: pc <= 4'h8;
        default: pc <= 4'h0;
      endcase
    end else if (tk) begin
      pc <= pc - 4'h1;
    end
  end

  // keep request magazine byte and border byte
  always_ff @(posedge clk_sys_i) begin
    if (tk && pc == 4'h8 && cmd == 8'h12) begin
      mb <= wr_data_i;
    end
    if (tk && pc == 4'h1 && cmd == 8'h38) begin
      bv <= wr_data_i;
    end
  end

  a_prio_rst_vals: assert property (
    $rose(resetn_i) |-> !prio_enable_o && prio_border_o == 8'hff)
    else $error("priority settings not at reset values");
  a_cycle_reply_lat: assert property (
    tk && pc == 4'h0 && wr_data_i == 8'h29 |=> !rd_valid_o ##1 rd_valid_o)
    else $error("page cycle reply late");
  a_prio_reply_lat: assert property (
    tk && pc == 4'h0 && wr_data_i == 8'h37 |=> !rd_valid_o ##1 rd_valid_o)
    else $error("priority reply late");
  a_req_one_pulse: assert property (
    tk && pc == 4'h1 && cmd == 8'h12 |-> ##[1:2] req_valid_o ##1 !req_valid_o)
    else $error("page request pulse missing");
  a_border_apply: assert property (
    tk && pc == 4'h1 && cmd == 8'h38 |-> ##[1:2] prio_border_o == bv)
    else $error("border byte not applied");
  a_rd_byte_hold: assert property (
    rd_valid_o && !rd_ack_i |=> rd_valid_o && $stable(rd_data_o))
    else $error("reply byte moved without ack");
  a_no_wr_in_rd: assert property (
    rd_valid_o |-> !wr_ready_o)
    else $error("write accepted during reply");
  a_border_clamp: assert property (
    req_valid_o && prio_enable_o |-> req_o.prio <= prio_border_o)
    else $error("request priority above border");
  a_start_use: assert property (
    req_valid_o |-> req_o.use_start == !prio_enable_o)
    else $error("start page use wrong");
  a_mag_decode: assert property (
    req_valid_o |-> req_o.mag == mb[3:0] && req_o.hex == mb[5]
      && req_o.backward == mb[6] && req_o.forced == mb[7])
    else $error("magazine byte decoded wrong");
endmodule

bind tpci_cmd_interp tpci_cmd_interp_asserts i_tpci_cmd_interp_asserts (.*);

// *** verification/tpci_host_model.sv ***
`timescale 1ns/10ps
// **********
// host side
// **********
module tpci_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic       wr_ready_i,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i,
  output      logic       wr_valid_o,
  output      logic [7:0] wr_data_o,
  output      logic       rd_ack_o,
  output      logic       hang_o
);
  int slow = 0;

  // idle host
  initial begin
    wr_valid_o = 1'b0;
    wr_data_o = 8'h00;
    rd_ack_o = 1'b0;
    hang_o = 1'b0;
  end

  // hold one byte until the device takes it
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wr_valid_o <= 1'b1;
    wr_data_o <= b;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!wr_ready_i && n < 64);
    if (!wr_ready_i) hang_o <= 1'b1;
    wr_valid_o <= 1'b0;
    wr_data_o <= ~b; // released data shows no stale value
  endtask

  // wait for a reply byte, take it and ack it
  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    repeat (slow) @(posedge clk_sys_i);
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!rd_valid_i && n < 64);
    if (!rd_valid_i) hang_o <= 1'b1;
    b = rd_data_i;
    rd_ack_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_ack_o <= 1'b0;
  endtask
endmodule

// *** verification/tpci_cmd_interp_tb_top.sv ***
`timescale 1ns/10ps
`include "tpci_params.svh"
// **********
// testbench
// **********
module tpci_cmd_interp_tb_top;
  import tpci_pkg::*;
  logic                    clk_sys_i, resetn_i, ce_i, wr_valid_i;
  logic                    wr_ready_o, rd_ack_i, rd_valid_o, hang;
  logic [7:0]              wr_data_i, rd_data_o, ghost_row_seen_i;
  logic [7:0]              open_req_i, removed_mag_i, removed_page_i;
  logic [5:0]              svc_event_i;
  logic                    table_reset_i, acq_we_i, acq_ready_o;
  logic                    req_valid_o, prio_enable_o;
  logic [7:0]              prio_border_o;
  logic [`TPCI_MEM_AW-1:0] acq_addr_i;
  tpci_entry_t             acq_entry_i;
  tpci_stats_t             stats_i;
  tpci_prio_t              prio_i;
  tpci_req_t               req_o, rq;
  int                      err_count, comparisons, acq_low;

  tpci_cmd_interp i_tpci_cmd_interp (.*);
  tpci_host_model i_tpci_host_model (.clk_sys_i(clk_sys_i),
    .wr_ready_i(wr_ready_o), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
    .wr_valid_o(wr_valid_i), .wr_data_o(wr_data_i), .rd_ack_o(rd_ack_i),
    .hang_o(hang));

  // clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // catch request pulses and table-busy cycles
  always @(posedge clk_sys_i) begin
    if (req_valid_o) rq <= req_o;
    if (!acq_ready_o) acq_low++;
  end

  // hung handshake ends the run
  always @(posedge hang) begin
    err_count++;
    report_and_stop();
  end

  task automatic report_and_stop();
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // send nw bytes of w, then check nr reply bytes of e
  task automatic xfer(input logic [71:0] w, input int nw, input int nr,
                      input logic [71:0] e);
    logic [7:0] b;
    for (int i = 0; i < nw; i++) i_tpci_host_model.put(w[8*(nw-1-i) +: 8]);
    for (int i = 0; i < nr; i++) begin
      i_tpci_host_model.get(b);
      cmp(b, e[8*(nr-1-i) +: 8]);
    end
  endtask

  task automatic wr_ent(input logic [10:0] a, input logic [63:0] v);
    @(posedge clk_sys_i);
    acq_we_i <= 1'b1;
    acq_addr_i <= a;
    acq_entry_i <= tpci_entry_t'(v);
    @(posedge clk_sys_i);
    acq_we_i <= 1'b0;
  endtask

  task automatic t_cycle();
    logic [71:0] e;
    @(posedge clk_sys_i);
    ghost_row_seen_i <= 8'ha5;
    svc_event_i <= 6'h2b;
    @(posedge clk_sys_i);
    ghost_row_seen_i <= 8'h00;
    svc_event_i <= 6'h00;
    e = {8'ha5, stats_i.cycle_cnt, stats_i.mem_cnt, stats_i.ghost_cnt,
         8'h2b, 8'h01};
    xfer(72'h29, 1, 9, e);
    // a table reset while frozen must leave the status alone
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    table_reset_i <= 1'b1;
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    table_reset_i <= 1'b0;
    xfer(72'h42, 1, 0, 72'h0);
    e[71:64] = 8'h00;
    i_tpci_host_model.slow = 3;
    xfer(72'h29, 1, 9, e);
    i_tpci_host_model.slow = 0;
  endtask

  task automatic t_prio();
    xfer(72'h38_0140, 3, 0, 72'h0);
    repeat (3) @(posedge clk_sys_i);
    cmp(prio_enable_o, 1'b1);
    cmp(prio_border_o, 8'h40);
    xfer(72'h37, 1, 5, {prio_i.highest, prio_i.lowest, 8'h40,
         prio_i.low_mag, prio_i.low_page});
  endtask

  task automatic t_req();
    xfer(72'h12_e345_3f7f_6002_0110, 9, 3,
         {open_req_i, removed_mag_i, removed_page_i});
    cmp({rq.mag, rq.hex, rq.backward, rq.forced}, 7'h1f);
    cmp(rq.prio, 8'h40);
    cmp(rq.use_start, 1'b0);
    cmp({rq.page, rq.subcode, rq.quantity}, 32'h453f_7f02);
    xfer(72'h38_00ff, 3, 0, 72'h0);
    xfer(72'h12_0245_3f7f_6002_0110, 9, 3,
         {open_req_i, removed_mag_i, removed_page_i});
    cmp({rq.mag, rq.hex, rq.backward, rq.forced}, 7'h10);
    cmp(rq.prio, 8'h60);
    cmp({rq.use_start, rq.start_mag, rq.start_page}, 17'h1_0110);
  endtask

  task automatic t_info();
    wr_ent(11'h321, 64'h0012_3405_0203_f107);
    wr_ent(11'h322, 64'h0056_7801_0409_1207);
    xfer(72'h20_0321, 3, 7, 56'h1234_0502_03f1_07);
    xfer(72'h20_0322, 3, 7, 56'h5678_0104_0000_00);
    acq_low = 0;
    xfer(72'h2203_21c3, 4, 0, 72'h0);
    repeat (3) @(posedge clk_sys_i);
    cmp(acq_low, 1);
    cmp(i_tpci_cmd_interp.u_mem.flag_mem[11'h321], 8'hc3);
    xfer(72'h20_0321, 3, 7, 56'h1234_0502_03f1_07);
  endtask

  // main sequence
  initial begin
    err_count = 0;
    comparisons = 0;
    acq_low = 0;
    resetn_i = 1'b0;
    ce_i = 1'b1;
    ghost_row_seen_i = 8'h00;
    svc_event_i = 6'h00;
    table_reset_i = 1'b0;
    acq_we_i = 1'b0;
    acq_addr_i = 11'h000;
    acq_entry_i = '0;
    stats_i = '{16'h0123, 16'h0456, 16'h0789, 1'b1};
    prio_i = '{8'h90, 8'h11, 8'h03, 8'h55};
    open_req_i = 8'h04;
    removed_mag_i = 8'h06;
    removed_page_i = 8'h77;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    cmp({prio_enable_o, prio_border_o}, 9'h0ff);
    t_cycle();
    t_prio();
    t_req();
    t_info();
    report_and_stop();
  end
endmodule
